// [logic/device_status_two.v]
/*
 * Second device status register of the power controller, with the
 * control bits it carries and their effect on the state sequencer.
 * Assumes an upstream SPI decoder hands over one-cycle command strobes
 * with an opcode and data byte, and that the sequencer takes the
 * transition requests produced here. Power-on reset drives rstn.
 */
`default_nettype none
`include "status_two_defines.vh"

module device_status_two #(
    parameter integer WAKE_FILT_CYC = `WAKE_FILT_CYC
) (
    input  wire       clk,               // system clock
    input  wire       rstn,              // power-on reset, active low
    input  wire       cmd_valid,         // one-cycle command strobe
    input  wire [3:0] cmd_op,            // decoded command code
    input  wire [7:0] cmd_data,          // command data byte
    input  wire [2:0] dev_state,         // current sequencer state
    input  wire       diag_timer_expired,// diagnostic time-out expiry
    input  wire       safe_timer_expired,// safe time-out expiry
    input  wire       global_reset_cond, // global reset condition
    input  wire       switcher_clock_select, // clock source select bit
    input  wire       ext_clock_monitor, // sync clock monitor enabled
    input  wire       sync_clk_in_range, // sync clock in range
    input  wire       mcu_err_in,        // MCU error pin level
    input  wire       wake_in,           // raw wake pin level
    output reg  [7:0] rd_data_q,         // read answer byte
    output reg        rd_valid_q,        // read answer strobe
    output reg        diag_timer_hold_q, // hold diagnostic timer in reset
    output reg        go_safe_q,         // request diagnostic to safe
    output reg        go_reset_q,        // request move to reset
    output reg        go_diag_q,         // request safe to diagnostic
    output reg  [7:0] device_status_two_q // live register view
);

    // ==========================================================
    // command decode
    function cmd_is;
        input       v;
        input [3:0] op;
        input [7:0] dat;
        input [3:0] want_op;
        input [7:0] want_dat;
        begin
            cmd_is = v && (op == want_op) && (dat == want_dat);
        end
    endfunction

    wire in_diag   = (dev_state == `ST_DIAG);
    wire in_safe   = (dev_state == `ST_SAFE);
    wire in_reset  = (dev_state == `ST_RESET);
    wire rst_ok    = in_diag || in_safe || (dev_state == `ST_ACTIVE);

    // non-matching data falls through untouched
    wire set_mask  = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_SET_DIAG_MASK, `KEY_SET);
    wire clr_mask  = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_CLR_DIAG_MASK, `KEY_CLR);
    wire set_off   = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_SAFE_TO_OFF, `KEY_SET) && in_diag;
    wire clr_off   = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_SAFE_TO_ON, `KEY_CLR) && in_diag;
    wire rst_req   = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_MCU_RST_REQ, `KEY_RST_REQ)
                     && rst_ok;
    wire clr_wake  = cmd_is(cmd_valid, cmd_op, cmd_data, `CMD_CLEAR_RESUME_LATCH_CMD, `KEY_CLR_WAKE);
    wire safe_exit = cmd_valid && (cmd_op == `CMD_SAFE_EXIT) && in_safe;
    wire rd_cmd    = cmd_valid && (cmd_op == `CMD_READ_ST2);

    // ==========================================================
    // wake filtering and edge
    wire wake_f;
    reg  wake_f_q;
    reg  wake_l_q;
    reg  state_off_q;

    wake_deglitch #(
        .FILT_CYC (WAKE_FILT_CYC)
    ) u_wake (
        .clk    (clk),
        .rstn   (rstn),
        .din    (wake_in),
        .dout_q (wake_f)
    );

    wire wake_rise  = wake_f && !wake_f_q;
    wire enter_off  = (dev_state == `ST_OFF) && !state_off_q;

    // ==========================================================
    // control bits
    reg diag_mask_q;
    reg safe_off_q;
    reg mcu_rst_q;
    reg reset_seen_q;
    reg go_reset_q_by_mcu;

    wire enter_reset = in_reset && !reset_seen_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            diag_mask_q  <= `ST2_RST_DIAG_MASK;
            safe_off_q   <= `ST2_RST_SAFE_OFF;
            mcu_rst_q    <= `ST2_RST_MCU_RST;
            reset_seen_q <= 1'b0;
            wake_f_q     <= 1'b0;
            wake_l_q     <= 1'b0;
            state_off_q  <= 1'b1;
        end else begin
            if (set_mask)
                diag_mask_q <= 1'b1;
            else if (clr_mask)
                diag_mask_q <= 1'b0;
            if (set_off)
                safe_off_q <= 1'b1;
            else if (clr_off)
                safe_off_q <= 1'b0;
            // flag follows cause of each new reset entry; reads never touch it
            if (rst_req)
                mcu_rst_q <= 1'b1;
            else if (enter_reset && !go_reset_q_by_mcu)
                mcu_rst_q <= 1'b0;
            reset_seen_q <= in_reset;
            wake_f_q     <= wake_f;
            state_off_q  <= (dev_state == `ST_OFF);
            // a new edge wins over a clear in the same cycle
            if (wake_rise)
                wake_l_q <= 1'b1;
            else if (clr_wake || enter_off)
                wake_l_q <= 1'b0;
        end
    end

    // remembers that the pending reset request came from the MCU
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            go_reset_q_by_mcu <= 1'b0;
        else if (rst_req)
            go_reset_q_by_mcu <= 1'b1;
        else if (global_reset_cond || (enter_reset && !rst_req))
            go_reset_q_by_mcu <= 1'b0;
    end

    // ==========================================================
    // register image
    wire sync_bit = switcher_clock_select && ext_clock_monitor && sync_clk_in_range;

    reg [7:0] image;
    always @* begin
        image = 8'h00;
        image[`ST2_BIT_RSVD]      = 1'b0;
        image[`ST2_BIT_DIAG_MASK] = diag_mask_q;
        image[`ST2_BIT_SAFE_OFF]  = safe_off_q;
        image[`ST2_BIT_MCU_RST]   = mcu_rst_q;
        image[`ST2_BIT_SYNC]      = sync_bit;
        image[`ST2_BIT_MCU_ERR]   = mcu_err_in;
        image[`ST2_BIT_WAKE_L]    = wake_l_q;
        image[`ST2_BIT_WAKE]      = wake_f;
    end

    // ==========================================================
    // outputs and transition requests
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_q           <= 8'h00;
            rd_valid_q          <= 1'b0;
            diag_timer_hold_q   <= 1'b0;
            go_safe_q           <= 1'b0;
            go_reset_q          <= 1'b0;
            go_diag_q           <= 1'b0;
            device_status_two_q <= 8'h20;
        end else begin
            rd_valid_q <= rd_cmd;
            rd_data_q  <= (rd_cmd && !in_reset) ? image : 8'h00;
            device_status_two_q <= image;
            diag_timer_hold_q   <= diag_mask_q;
            go_safe_q  <= in_diag && !diag_mask_q && diag_timer_expired;
            go_reset_q <= rst_req
                          || (in_safe && global_reset_cond)
                          || (in_safe && !safe_off_q && safe_timer_expired);
            go_diag_q  <= safe_exit;
        end
    end

endmodule

`default_nettype wire

// [shared/status_two_defines.vh]
/*
 * Constants for the second device status register: field positions,
 * reset values, command codes, command data keys and state codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef STATUS_TWO_DEFINES_VH
`define STATUS_TWO_DEFINES_VH

// ==========================================================
// field positions
`define ST2_BIT_RSVD        7
`define ST2_BIT_DIAG_MASK   6
`define ST2_BIT_SAFE_OFF    5
`define ST2_BIT_MCU_RST     4
`define ST2_BIT_SYNC        3
`define ST2_BIT_MCU_ERR     2
`define ST2_BIT_WAKE_L      1
`define ST2_BIT_WAKE        0

// ==========================================================
// reset values
`define ST2_RST_DIAG_MASK   1'b0
`define ST2_RST_SAFE_OFF    1'b1
`define ST2_RST_MCU_RST     1'b0

// ==========================================================
// command codes (decoded upstream, arbitrary local encoding)
`define CMD_NONE            4'h0
`define CMD_READ_ST2        4'h1
`define CMD_SET_DIAG_MASK   4'h2
`define CMD_CLR_DIAG_MASK   4'h3
`define CMD_SAFE_TO_OFF     4'h4
`define CMD_SAFE_TO_ON      4'h5
`define CMD_MCU_RST_REQ     4'h6
`define CMD_SAFE_EXIT       4'h7
`define CMD_CLEAR_RESUME_LATCH_CMD  4'h8

// ==========================================================
// command data keys
`define KEY_SET             8'h55
`define KEY_CLR             8'hAA
`define KEY_RST_REQ         8'h5A
`define KEY_CLR_WAKE        8'h8E

// ==========================================================
// device states
`define ST_OFF              3'h0
`define ST_DIAG             3'h1
`define ST_ACTIVE           3'h2
`define ST_RESET            3'h3
`define ST_SAFE             3'h4

// ==========================================================
// wake deglitch length in cycles
`define WAKE_FILT_CYC       8

`endif

// [logic/wake_deglitch.v]
/*
 * Wake input deglitch filter: the output follows the input once the
 * input has held one level for FILT_CYC consecutive cycles.
 * Assumes the input is already synchronous to clk.
 */
`default_nettype none
`include "status_two_defines.vh"

module wake_deglitch #(
    parameter integer FILT_CYC = `WAKE_FILT_CYC
) (
    input  wire clk,    // system clock
    input  wire rstn,   // async reset, active low
    input  wire din,    // raw wake level
    output reg  dout_q  // filtered wake level
);

    localparam integer CW = (FILT_CYC < 2) ? 1 : $clog2(FILT_CYC + 1);
    localparam [CW-1:0] LAST = FILT_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

    reg [CW-1:0] cnt_q;

    // ==========================================================
    // filter
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= {CW{1'b0}};
            dout_q <= 1'b0;
        end else if (din == dout_q) begin
            cnt_q <= {CW{1'b0}};
        end else if (cnt_q >= LAST) begin
            // level held long enough: accept it
            cnt_q  <= {CW{1'b0}};
            dout_q <= din;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// [dv/st2_assertions.sv]
/* assertions on the status register ports
   assumes a single clock domain, bound to each register block below */
`default_nettype none
`include "status_two_defines.vh"
// ====================
// checker
module st2_chk (
    input wire logic       clk,                 // clock
    input wire logic       rstn,                // reset, low
    input wire logic       cmd_valid,           // strobe
    input wire logic [3:0] cmd_op,              // opcode
    input wire logic [2:0] dev_state,           // state
    input wire logic       diag_timer_expired,  // diag expiry
    input wire logic       safe_timer_expired,  // safe expiry
    input wire logic [7:0] rd_data_q,           // answer
    input wire logic       rd_valid_q,          // answer strobe
    input wire logic       diag_timer_hold_q,   // diag hold
    input wire logic       go_safe_q,           // to safe
    input wire logic       go_reset_q,          // to reset
    input wire logic [7:0] device_status_two_q  // image
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_rsvd; !device_status_two_q[7]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_hold; diag_timer_hold_q == device_status_two_q[6]; endproperty
    a_hold: assert property (p_hold) else $error("hold differs from mask");
    property p_safe; $past(diag_timer_expired && dev_state == `ST_DIAG)
        && !device_status_two_q[6] && !$past(device_status_two_q[6]) |-> go_safe_q; endproperty
    a_safe: assert property (p_safe) else $error("no move to safe");
    property p_nosafe; device_status_two_q[6] && $past(device_status_two_q[6]) |-> !go_safe_q;
    endproperty
    a_nosafe: assert property (p_nosafe) else $error("masked move to safe");
    property p_sto; $past(safe_timer_expired && dev_state == `ST_SAFE)
        && !device_status_two_q[5] && !$past(device_status_two_q[5]) |-> go_reset_q; endproperty
    a_sto: assert property (p_sto) else $error("no safe time-out reset");
    property p_rd; rd_valid_q == $past(cmd_valid && cmd_op == `CMD_READ_ST2); endproperty
    a_rd: assert property (p_rd) else $error("answer strobe wrong");
    property p_rdd; cmd_valid && cmd_op == `CMD_READ_ST2 && dev_state != `ST_RESET
        |=> rd_data_q == device_status_two_q; endproperty
    a_rdd: assert property (p_rdd) else $error("answer differs from image");
    property p_rdz; cmd_valid && cmd_op == `CMD_READ_ST2 && dev_state == `ST_RESET
        |=> rd_valid_q && rd_data_q == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("answer not zero in reset");
endmodule
bind device_status_two st2_chk chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .dev_state(dev_state), .diag_timer_expired(diag_timer_expired),
    .safe_timer_expired(safe_timer_expired), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .diag_timer_hold_q(diag_timer_hold_q), .go_safe_q(go_safe_q), .go_reset_q(go_reset_q),
    .device_status_two_q(device_status_two_q));
`default_nettype wire

// [dv/mcu_cmd_model.sv]
/* controller model issuing one command per call
   assumes the bench supplies clk */
`default_nettype none
// ====================
// controller model
module mcu_cmd_model (
    input  wire logic       clk,       // clock
    output logic            cmd_valid, // strobe
    output logic [3:0]      cmd_op,    // opcode
    output logic [7:0]      cmd_data   // data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_data = 8'h00;
    end
    task automatic send(input logic [3:0] op, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // idle fields inverted so a stale value never looks valid
        cmd_op <= ~op;
        cmd_data <= ~d;
    endtask
endmodule
`default_nettype wire

// [dv/device_status_two_tb.sv]
/* self-checking bench for the second status register
   assumes the defines header on the include path */
`default_nettype none
`include "status_two_defines.vh"
// ====================
// bench
module device_status_two_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmd_valid;
    logic [3:0] cmd_op;
    logic [7:0] cmd_data;
    logic [2:0] dev_state = `ST_DIAG;
    logic       diag_exp = 1'b0;
    logic       safe_exp = 1'b0;
    logic       clk_sel = 1'b0;
    logic       mon_en = 1'b0;
    logic       in_rng = 1'b0;
    logic       err_pin = 1'b0;
    logic       wake_pin = 1'b0;
    logic [7:0] rd_data;
    logic       go_safe;
    logic       go_reset;
    logic       go_diag;
    logic       hold;
    logic       glob_rst = 1'b0;
    int         miscompares = 0;
    int         checks_done = 0;
    always #10 clk = ~clk;
    mcu_cmd_model mcu (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data));
    device_status_two #(.WAKE_FILT_CYC(4)) dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .dev_state(dev_state),
        .diag_timer_expired(diag_exp), .safe_timer_expired(safe_exp),
        .global_reset_cond(glob_rst),
        .switcher_clock_select(clk_sel), .ext_clock_monitor(mon_en),
        .sync_clk_in_range(in_rng), .mcu_err_in(err_pin), .wake_in(wake_pin),
        .rd_data_q(rd_data), .rd_valid_q(), .diag_timer_hold_q(hold), .go_safe_q(go_safe),
        .go_reset_q(go_reset), .go_diag_q(go_diag), .device_status_two_q());
    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        mcu.send(`CMD_READ_ST2, 8'h00);
        #1;
        chk("status", exp, rd_data);
    endtask
    task automatic go(input logic [2:0] s, input int n);
        @(posedge clk);
        dev_state <= s;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h20);
        mcu.send(`CMD_SET_DIAG_MASK, 8'h54);
        rd(8'h20);
        mcu.send(`CMD_SET_DIAG_MASK, 8'h55);
        rd(8'h60);
        chk("hold", 8'h01, {7'h00, hold});
        @(posedge clk) diag_exp <= 1'b1;
        go(`ST_DIAG, 4);
        chk("go_safe", 8'h00, {7'h00, go_safe});
        mcu.send(`CMD_CLR_DIAG_MASK, 8'hAA);
        go(`ST_DIAG, 3);
        chk("go_safe", 8'h01, {7'h00, go_safe});
        rd(8'h20);
        @(posedge clk);
        diag_exp <= 1'b0;
        safe_exp <= 1'b1;
        go(`ST_SAFE, 4);
        chk("go_reset", 8'h00, {7'h00, go_reset});
        go(`ST_DIAG, 1);
        mcu.send(`CMD_SAFE_TO_ON, 8'hAA);
        go(`ST_ACTIVE, 1);
        mcu.send(`CMD_SAFE_TO_OFF, 8'h55);
        rd(8'h00);
        go(`ST_SAFE, 4);
        chk("go_reset", 8'h01, {7'h00, go_reset});
        @(posedge clk) safe_exp <= 1'b0;
        mcu.send(`CMD_MCU_RST_REQ, 8'h5A);
        go(`ST_RESET, 2);
        rd(8'h00);
        go(`ST_DIAG, 2);
        rd(8'h10);
        rd(8'h10);
        @(posedge clk);
        err_pin <= 1'b1;
        wake_pin <= 1'b1;
        clk_sel <= 1'b1;
        mon_en <= 1'b1;
        in_rng <= 1'b1;
        go(`ST_DIAG, 10);
        rd(8'h1F);
        @(posedge clk) wake_pin <= 1'b0;
        go(`ST_DIAG, 10);
        rd(8'h1E);
        mcu.send(`CMD_CLEAR_RESUME_LATCH_CMD, 8'h8E);
        rd(8'h1C);
        @(posedge clk);
        wake_pin <= 1'b1;
        mon_en <= 1'b0;
        go(`ST_DIAG, 10);
        go(`ST_OFF, 3);
        go(`ST_DIAG, 2);
        rd(8'h15);
        go(`ST_SAFE, 2);
        mcu.send(`CMD_SAFE_EXIT, 8'h00);
        #1;
        chk("go_diag", 8'h01, {7'h00, go_diag});
        go(`ST_DIAG, 1);
        mcu.send(`CMD_SAFE_EXIT, 8'h00);
        #1;
        chk("go_diag", 8'h00, {7'h00, go_diag});
        go(`ST_SAFE, 1);
        @(posedge clk) glob_rst <= 1'b1;
        go(`ST_SAFE, 2);
        chk("go_reset", 8'h01, {7'h00, go_reset});
        go(`ST_RESET, 2);
        @(posedge clk) glob_rst <= 1'b0;
        go(`ST_DIAG, 2);
        rd(8'h05);
        tally_and_finish();
    end
    // run needs roughly 140 cycles
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
